/* File: hdl/accel_output_regs.sv */
// Summary of operation
// - status at 0x00, reset 0x01, burst advances
// - temperature at 0x01, skipped unless enabled
// - magnitude bytes at 0x02/0x03, endian split
// - magnitude enable low skips both magnitude bytes
// - X acceleration bytes at 0x04/0x05
// - Y acceleration bytes at 0x06/0x07
// - Z acceleration bytes at 0x08/0x09
// - axis skip bit skips both axis bytes
// - fast read jumps over high bytes
// - after 0x09 pointer wraps to 0x00
// - 0x0a reserved, reads 0x00, not in ring
// - store state at 0x0b, then 0x0c/0x0e/0x10
// - stored X low at 0x0c, pointer rules
// - endian, temp increment, fast read in 0x16
// - axis skip bits live in 0x19
`timescale 1ns/100ps
`default_nettype none

module accel_output_regs (
  // clock and reset
  input  wire logic                                 clk,
  input  wire logic                                 rstn,
  // serial port side register access
  input  wire logic                                 addrLoad,
  input  wire logic [accel_regs_pkg::ADDR_W-1:0]   addrIn,
  input  wire logic                                 readStrobe,
  output logic      [accel_regs_pkg::DATA_W-1:0]   readData,
  output logic                                      readValid,
  output logic      [accel_regs_pkg::ADDR_W-1:0]   readPointer,
  // configuration registers held elsewhere
  input  wire logic [accel_regs_pkg::DATA_W-1:0]   sensorSetupTwo,
  input  wire logic [accel_regs_pkg::DATA_W-1:0]   sensorSetupFive,
  // live sensor data
  input  wire logic [accel_regs_pkg::DATA_W-1:0]   eventFlags,
  input  wire logic [accel_regs_pkg::DATA_W-1:0]   temperature,
  input  wire logic [accel_regs_pkg::SAMPLE_W-1:0] magnitude,
  input  wire logic [accel_regs_pkg::SAMPLE_W-1:0] accelX,
  input  wire logic [accel_regs_pkg::SAMPLE_W-1:0] accelY,
  input  wire logic [accel_regs_pkg::SAMPLE_W-1:0] accelZ,
  // sample store
  input  wire logic                                 storeWatermark,
  input  wire logic                                 storeOverflow,
  input  wire logic [accel_regs_pkg::COUNT_W-1:0]  storeCount,
  input  wire logic [accel_regs_pkg::SAMPLE_W-1:0] storedX
);
  import accel_regs_pkg::*;

  // ***************************************************************
  // state
  // ***************************************************************
  // status copies are registered so a read returns one coherent byte
  typedef struct packed {
    logic [ADDR_W-1:0] pointer;
    logic [DATA_W-1:0] readData;
    logic              readValid;
    logic [DATA_W-1:0] eventStatus;
    logic [DATA_W-1:0] storeState;
  } regs_t;

  regs_t state_r;
  regs_t state_nxt;

  logic rstSync1_r;
  logic rstSync2_r;

  // ***************************************************************
  // reset release
  // ***************************************************************
  // release is synchronised so no flop sees a partial edge
  // release lands on the second rising edge after rstn goes high
  // only the second stage is read, the first may still be settling
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1_r <= 1'b0;
      rstSync2_r <= 1'b0;
    end else begin
      rstSync1_r <= 1'b1;
      rstSync2_r <= rstSync1_r;
    end
  end

  // ***************************************************************
  // configuration fields
  // ***************************************************************
  logic endianSelect;
  logic temperatureAutoincEnable;
  logic fastRead;
  logic magnitudeEnable;
  logic xAxisSkip;
  logic yAxisSkip;
  logic zAxisSkip;

  // fields taken from the two setup registers
  // these are levels; a change counts from the very next read
  // the hibernate bit is handled elsewhere and never stalls a read
  assign endianSelect             = sensorSetupTwo[SETUP2_ENDIAN_SELECT_BIT];
  assign temperatureAutoincEnable = sensorSetupTwo[SETUP2_TEMP_AUTOINC_BIT];
  assign fastRead                 = sensorSetupTwo[SETUP2_FAST_READ_BIT];
  assign magnitudeEnable          = sensorSetupFive[SETUP5_VECM_ENABLE_BIT];
  assign xAxisSkip                = sensorSetupFive[SETUP5_X_AXIS_SKIP_BIT];
  assign yAxisSkip                = sensorSetupFive[SETUP5_Y_AXIS_SKIP_BIT];
  assign zAxisSkip                = sensorSetupFive[SETUP5_Z_AXIS_SKIP_BIT];

  // ***************************************************************
  // byte split of the 12-bit values
  // ***************************************************************
  logic [SAMPLE_W-1:0] chValue [NUM_CH];
  logic [DATA_W-1:0]   chLow   [NUM_CH];
  logic [DATA_W-1:0]   chHigh  [NUM_CH];

  // channel slots follow the package indices
  assign chValue[CH_MAGNITUDE] = magnitude;
  assign chValue[CH_X]         = accelX;
  assign chValue[CH_Y]         = accelY;
  assign chValue[CH_Z]         = accelZ;
  assign chValue[CH_STORED_X]  = storedX;

  // one splitter per channel, all following the same endian select
  // the stored sample shares it, so both banks always agree on order
  for (genvar g = 0; g < NUM_CH; g++) begin : gSplit
    byte_splitter uSplit (
      .value        (chValue[g]),
      .endianSelect (endianSelect),
      .lowByte      (chLow[g]),
      .highByte     (chHigh[g])
    );
  end

  // ***************************************************************
  // auto-increment enables of the main ring
  // ***************************************************************
  logic [9:0] ringEnable;

  // a bit set means the burst pointer may stop on that address
  // status has no enable, so a burst can always fall back onto it
  always_comb begin
    ringEnable    = '0;
    ringEnable[0] = 1'b1;
    ringEnable[1] = temperatureAutoincEnable;
    ringEnable[2] = magnitudeEnable;
    ringEnable[3] = magnitudeEnable;
    ringEnable[4] = !xAxisSkip;
    ringEnable[5] = !xAxisSkip;
    ringEnable[6] = !yAxisSkip;
    ringEnable[7] = !yAxisSkip;
    ringEnable[8] = !zAxisSkip;
    ringEnable[9] = !zAxisSkip;
  end

  // first enabled ring address at or above start, else wrap to status
  // a linear scan is cheap at ten entries and keeps the order plain
  function automatic logic [ADDR_W-1:0] ringNext(input logic [3:0] start,
                                                 input logic [9:0] en);
    logic [ADDR_W-1:0] res;
    logic              found;
    res   = ADDR_EVENT_STATUS;
    found = 1'b0;
    for (int i = 1; i < 10; i++) begin
      if (!found && (4'(i) >= start) && en[i]) begin
        res   = 8'(i);
        found = 1'b1;
      end
    end
    return res;
  endfunction

  // first enabled stored-sample low byte, x then y then z
  // with every axis skipped the fallback keeps the pointer in the store
  function automatic logic [ADDR_W-1:0] storeNext(input logic xOn,
                                                  input logic yOn,
                                                  input logic zOn,
                                                  input logic [ADDR_W-1:0] fallback);
    logic [ADDR_W-1:0] res;
    res = fallback;
    if (xOn) begin
      res = ADDR_STORED_X_LOW;
    end else if (yOn) begin
      res = ADDR_STORED_Y_LOW;
    end else if (zOn) begin
      res = ADDR_STORED_Z_LOW;
    end
    return res;
  endfunction

  // ***************************************************************
  // next pointer after a read
  // ***************************************************************
  logic [ADDR_W-1:0] nextPointer;
  logic              isLowByte;
  logic [3:0]        ringStart;

  // fast read hops over the high byte of the value just read
  // magnitude low counts too, so fast read also drops its high byte
  // ringStart only matters while the pointer sits inside the ring
  assign isLowByte = (state_r.pointer == ADDR_MAGNITUDE_LOW) ||
                     (state_r.pointer == ADDR_ACCEL_X_LOW) ||
                     (state_r.pointer == ADDR_ACCEL_Y_LOW) ||
                     (state_r.pointer == ADDR_ACCEL_Z_LOW);
  assign ringStart = (fastRead && isLowByte) ? state_r.pointer[3:0] + 4'h2
                                             : state_r.pointer[3:0] + 4'h1;

  // plain increment covers the high store bytes and unmapped space,
  // and 0xff rolls over to 0x00 by itself
  always_comb begin
    nextPointer = state_r.pointer + 8'h01;
    if (state_r.pointer <= {4'h0, RING_LAST}) begin
      // past 0x09 nothing is enabled, so the ring closes on status
      nextPointer = ringNext(ringStart, ringEnable);
    end else if (state_r.pointer == ADDR_FACTORY_RSVD_A) begin
      nextPointer = ADDR_STORE_STATE;
    end else if (state_r.pointer == ADDR_STORE_STATE) begin
      nextPointer = storeNext(!xAxisSkip, !yAxisSkip, !zAxisSkip,
                              ADDR_STORED_X_LOW);
    end else if (state_r.pointer == ADDR_STORED_X_LOW) begin
      if (fastRead) begin
        nextPointer = storeNext(1'b0, !yAxisSkip, !zAxisSkip,
                                ADDR_STORED_X_LOW);
      end else begin
        nextPointer = ADDR_STORED_X_HIGH;
      end
    end
  end

  // ***************************************************************
  // read data selection
  // ***************************************************************
  logic [DATA_W-1:0] selData;

  // the addressed byte is returned whether or not the ring skips it
  // unmapped addresses read zero so a stray burst shows no stale byte
  always_comb begin
    unique case (state_r.pointer)
      ADDR_EVENT_STATUS:   selData = state_r.eventStatus;
      ADDR_TEMPERATURE:    selData = temperature;
      ADDR_MAGNITUDE_LOW:  selData = chLow[CH_MAGNITUDE];
      ADDR_MAGNITUDE_HIGH: selData = chHigh[CH_MAGNITUDE];
      ADDR_ACCEL_X_LOW:    selData = chLow[CH_X];
      ADDR_ACCEL_X_HIGH:   selData = chHigh[CH_X];
      ADDR_ACCEL_Y_LOW:    selData = chLow[CH_Y];
      ADDR_ACCEL_Y_HIGH:   selData = chHigh[CH_Y];
      ADDR_ACCEL_Z_LOW:    selData = chLow[CH_Z];
      ADDR_ACCEL_Z_HIGH:   selData = chHigh[CH_Z];
      ADDR_FACTORY_RSVD_A: selData = RST_FACTORY_RSVD_A;
      ADDR_STORE_STATE:    selData = state_r.storeState;
      ADDR_STORED_X_LOW:   selData = chLow[CH_STORED_X];
      default:             selData = 8'h00;  // outside this bank
    endcase
  end

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    state_nxt           = state_r;
    // valid is a one-cycle pulse per read; back-to-back reads keep it high
    state_nxt.readValid = 1'b0;
    // status copies follow the live flags every cycle
    state_nxt.eventStatus = eventFlags;
    state_nxt.storeState  = '0;
    state_nxt.storeState[STORE_WATERMARK_BIT] = storeWatermark;
    state_nxt.storeState[STORE_OVERFLOW_BIT]  = storeOverflow;
    state_nxt.storeState[COUNT_W-1:0]         = storeCount;
    // a new start address overrides a read in the same cycle
    // so a host restarting a burst never gets a byte from the old one
    if (addrLoad) begin
      state_nxt.pointer = addrIn;
    end else if (readStrobe) begin
      state_nxt.readData  = selData;
      state_nxt.readValid = 1'b1;
      state_nxt.pointer   = nextPointer;
    end
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  // only constants in the reset branch, so the async path stays clean
  // the whole struct moves at once, so no field lags the others
  always_ff @(posedge clk or negedge rstSync2_r) begin
    if (!rstSync2_r) begin
      state_r.pointer     <= RST_POINTER;
      state_r.readData    <= RST_READ_DATA;
      state_r.readValid   <= 1'b0;
      state_r.eventStatus <= RST_EVENT_STATUS;
      state_r.storeState  <= RST_STORE_STATE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  // all three come straight from flops, so the host sees no glitches
  assign readData    = state_r.readData;
  assign readValid   = state_r.readValid;
  assign readPointer = state_r.pointer;

endmodule
`default_nettype wire

/* File: hdl/accel_regs_pkg.sv */
package accel_regs_pkg;

  // ***************************************************************
  // widths
  // ***************************************************************
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned SAMPLE_W = 12;
  localparam int unsigned COUNT_W  = 6;
  localparam int unsigned NUM_CH   = 5;

  // ***************************************************************
  // register offsets
  // ***************************************************************
  localparam logic [7:0] ADDR_EVENT_STATUS   = 8'h00;
  localparam logic [7:0] ADDR_TEMPERATURE    = 8'h01;
  localparam logic [7:0] ADDR_MAGNITUDE_LOW  = 8'h02;
  localparam logic [7:0] ADDR_MAGNITUDE_HIGH = 8'h03;
  localparam logic [7:0] ADDR_ACCEL_X_LOW    = 8'h04;
  localparam logic [7:0] ADDR_ACCEL_X_HIGH   = 8'h05;
  localparam logic [7:0] ADDR_ACCEL_Y_LOW    = 8'h06;
  localparam logic [7:0] ADDR_ACCEL_Y_HIGH   = 8'h07;
  localparam logic [7:0] ADDR_ACCEL_Z_LOW    = 8'h08;
  localparam logic [7:0] ADDR_ACCEL_Z_HIGH   = 8'h09;
  localparam logic [7:0] ADDR_FACTORY_RSVD_A = 8'h0a;
  localparam logic [7:0] ADDR_STORE_STATE    = 8'h0b;
  localparam logic [7:0] ADDR_STORED_X_LOW   = 8'h0c;
  localparam logic [7:0] ADDR_STORED_X_HIGH  = 8'h0d;
  localparam logic [7:0] ADDR_STORED_Y_LOW   = 8'h0e;
  localparam logic [7:0] ADDR_STORED_Z_LOW   = 8'h10;
  localparam logic [7:0] ADDR_SENSOR_SETUP_TWO  = 8'h16;
  localparam logic [7:0] ADDR_SENSOR_SETUP_FIVE = 8'h19;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [7:0] RST_EVENT_STATUS   = 8'h01;
  localparam logic [7:0] RST_FACTORY_RSVD_A = 8'h00;
  localparam logic [7:0] RST_STORE_STATE    = 8'h00;
  localparam logic [7:0] RST_READ_DATA      = 8'h00;
  localparam logic [7:0] RST_POINTER        = 8'h00;

  // ***************************************************************
  // field positions
  // ***************************************************************
  // sensor_setup_two
  localparam int unsigned SETUP2_ENDIAN_SELECT_BIT = 0;
  localparam int unsigned SETUP2_TEMP_AUTOINC_BIT  = 1;
  localparam int unsigned SETUP2_FAST_READ_BIT     = 2;
  // sensor_setup_five
  localparam int unsigned SETUP5_VECM_ENABLE_BIT   = 3;
  localparam int unsigned SETUP5_HIBERNATE_BIT     = 4;
  localparam int unsigned SETUP5_Z_AXIS_SKIP_BIT   = 5;
  localparam int unsigned SETUP5_Y_AXIS_SKIP_BIT   = 6;
  localparam int unsigned SETUP5_X_AXIS_SKIP_BIT   = 7;
  // sample_store_state
  localparam int unsigned STORE_WATERMARK_BIT = 7;
  localparam int unsigned STORE_OVERFLOW_BIT  = 6;

  // channel order of the byte splitters
  localparam int unsigned CH_MAGNITUDE = 0;
  localparam int unsigned CH_X         = 1;
  localparam int unsigned CH_Y         = 2;
  localparam int unsigned CH_Z         = 3;
  localparam int unsigned CH_STORED_X  = 4;

  // last address of the main burst ring
  localparam logic [3:0] RING_LAST = 4'h9;

endpackage

/* File: hdl/byte_splitter.sv */
`timescale 1ns/100ps
`default_nettype none

// splits one 12-bit value into its two register bytes
module byte_splitter (
  // sample
  input  wire logic [accel_regs_pkg::SAMPLE_W-1:0] value,
  input  wire logic                                 endianSelect,
  // register bytes
  output logic      [accel_regs_pkg::DATA_W-1:0]   lowByte,
  output logic      [accel_regs_pkg::DATA_W-1:0]   highByte
);
  import accel_regs_pkg::*;

  // little order puts bits 7:0 first, big order bits 11:4 first
  always_comb begin
    if (endianSelect) begin
      lowByte  = value[11:4];
      highByte = {value[3:0], 4'h0};
    end else begin
      lowByte  = value[7:0];
      highByte = {4'h0, value[11:8]};
    end
  end

endmodule
`default_nettype wire

/* File: dv/accel_output_regs_chk.sv */
`timescale 1ns/100ps
`default_nettype none

// ***************************************************************
// read port checker
// ***************************************************************
module accel_output_regs_chk (
  // clock and reset
  input wire logic                                 clk,
  input wire logic                                 rstn,
  // register port
  input wire logic                                 addrLoad,
  input wire logic [accel_regs_pkg::ADDR_W-1:0]   addrIn,
  input wire logic                                 readStrobe,
  input wire logic [accel_regs_pkg::DATA_W-1:0]   readData,
  input wire logic                                 readValid,
  input wire logic [accel_regs_pkg::ADDR_W-1:0]   readPointer,
  // configuration and data
  input wire logic [accel_regs_pkg::DATA_W-1:0]   sensorSetupTwo,
  input wire logic [accel_regs_pkg::DATA_W-1:0]   sensorSetupFive,
  input wire logic [accel_regs_pkg::DATA_W-1:0]   eventFlags,
  input wire logic [accel_regs_pkg::SAMPLE_W-1:0] accelX
);
  import accel_regs_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // a load in the same cycle wins, so a read is a strobe without one
  sequence readReq;
    readStrobe && !addrLoad;
  endsequence
  sequence readAt(logic [7:0] a);
    readReq ##0 (readPointer == a);
  endsequence

  AST_VALID_AFTER_READ: assert property (readReq |=> readValid)
    else $error("no valid after a read");
  AST_NO_STRAY_VALID: assert property (!(readStrobe && !addrLoad) |=> !readValid)
    else $error("valid without a read");
  AST_LOAD_POINTER: assert property (addrLoad |=> readPointer == $past(addrIn))
    else $error("pointer not loaded");
  // status is copied each cycle, so the byte holds the flags of the edge before the read
  AST_STATUS_DATA: assert property (
    readAt(ADDR_EVENT_STATUS) |=> readData == $past(eventFlags, 2))
    else $error("status byte wrong");
  AST_RING_WRAP: assert property (readAt(ADDR_ACCEL_Z_HIGH) |=> readPointer == 8'h00)
    else $error("no wrap after z high");
  AST_RESERVED_READ: assert property (
    readAt(8'h0a) |=> readData == 8'h00 && readPointer == 8'h0b)
    else $error("reserved location wrong");
  AST_STORE_NEXT: assert property (
    readAt(8'h0b) ##0 !sensorSetupFive[SETUP5_X_AXIS_SKIP_BIT] |=> readPointer == 8'h0c)
    else $error("store state next wrong");
  AST_X_LOW_DATA: assert property (
    readAt(8'h04) ##0 !sensorSetupTwo[SETUP2_ENDIAN_SELECT_BIT]
    |=> readData == $past(accelX[7:0]))
    else $error("x low byte wrong");
  // without fast read or x skip, a direct read of x low moves on to its high byte
  AST_X_NORMAL_NEXT: assert property (
    readAt(8'h04) ##0 !sensorSetupTwo[SETUP2_FAST_READ_BIT]
    ##0 !sensorSetupFive[SETUP5_X_AXIS_SKIP_BIT] |=> readPointer == 8'h05)
    else $error("x low next wrong");
  AST_X_FAST_NEXT: assert property (
    readAt(8'h04) ##0 sensorSetupTwo[SETUP2_FAST_READ_BIT]
    ##0 !sensorSetupFive[SETUP5_Y_AXIS_SKIP_BIT] |=> readPointer == 8'h06)
    else $error("fast read next wrong");
endmodule

bind accel_output_regs accel_output_regs_chk accel_output_regs_chk_i (
  .clk(clk), .rstn(rstn), .addrLoad(addrLoad), .addrIn(addrIn), .readStrobe(readStrobe),
  .readData(readData), .readValid(readValid), .readPointer(readPointer),
  .sensorSetupTwo(sensorSetupTwo), .sensorSetupFive(sensorSetupFive),
  .eventFlags(eventFlags), .accelX(accelX));

`default_nettype wire

/* File: dv/accel_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ***************************************************************
// host side of the register read port
// ***************************************************************
module accel_host_model (
  // clock
  input  wire logic       clk,
  // requests to the device
  output var  logic       addrLoad,
  output var  logic [7:0] addrIn,
  output var  logic       readStrobe,
  // answers from the device
  input  wire logic [7:0] readData,
  input  wire logic       readValid
);
  initial begin
    addrLoad = 1'b0;
    addrIn = 8'h00;
    readStrobe = 1'b0;
  end

  // entered at a falling edge; address released as its inverse so no stale value lingers
  task automatic loadAddr(input logic [7:0] a, input logic rd);
    addrLoad = 1'b1;
    addrIn = a;
    if (rd) readStrobe = 1'b1;
    @(posedge clk);
    @(negedge clk);
    addrLoad = 1'b0;
    addrIn = ~a;
    if (rd) readStrobe = 1'b0;
  endtask

  // keep leaves the strobe up so back-to-back reads need no gap
  task automatic readOne(input logic keep, output logic [7:0] d, output logic v);
    if (!readStrobe) readStrobe = 1'b1;
    @(posedge clk);
    @(negedge clk);
    d = readData;
    v = readValid;
    if (!keep) readStrobe = 1'b0;
  endtask

  // rebuild a 12-bit value with the same byte order the device used
  function automatic logic [11:0] joinBytes(input logic [7:0] lo, hi, input logic endian);
    return endian ? {lo, hi[7:4]} : {hi[3:0], lo};
  endfunction
endmodule

`default_nettype wire

/* File: dv/accel_output_regs_tb.sv */
`timescale 1ns/100ps
`default_nettype none

module accel_output_regs_tb;
  import accel_regs_pkg::*;

  typedef struct packed {
    logic [7:0] setTwo, setFive, addr, data, next;
  } row_t;

  // ***************************************************************
  // single reads: setup two, setup five, start, byte, next pointer
  // ***************************************************************
  localparam row_t ROWS [25] = '{
    '{8'h00,8'h00,8'h00,8'h5a,8'h04},
    '{8'h02,8'h08,8'h00,8'h5a,8'h01},
    '{8'h02,8'h00,8'h01,8'h3c,8'h04},
    '{8'h00,8'h08,8'h01,8'h3c,8'h02},
    '{8'h00,8'h08,8'h02,8'hbc,8'h03},
    '{8'h01,8'h08,8'h02,8'hab,8'h03},
    '{8'h01,8'h08,8'h03,8'hc0,8'h04},
    '{8'h00,8'h08,8'h03,8'h0a,8'h04},
    '{8'h01,8'h00,8'h05,8'h30,8'h06},
    '{8'h04,8'h40,8'h04,8'h23,8'h08},
    '{8'h04,8'h60,8'h04,8'h23,8'h00},
    '{8'h00,8'h00,8'h06,8'h56,8'h07},
    '{8'h01,8'h20,8'h07,8'h60,8'h00},
    '{8'h04,8'h00,8'h08,8'h89,8'h00},
    '{8'h00,8'h00,8'h09,8'h07,8'h00},
    '{8'h00,8'h00,8'h0a,8'h00,8'h0b},
    '{8'h00,8'h00,8'h0b,8'h95,8'h0c},
    '{8'h00,8'h80,8'h0b,8'h95,8'h0e},
    '{8'h00,8'hc0,8'h0b,8'h95,8'h10},
    '{8'h00,8'he0,8'h0b,8'h95,8'h0c},
    '{8'h01,8'h00,8'h0c,8'hde,8'h0d},
    '{8'h04,8'h40,8'h0c,8'hef,8'h10},
    '{8'h04,8'h60,8'h0c,8'hef,8'h0c},
    '{8'h00,8'h80,8'h04,8'h23,8'h06},
    '{8'h00,8'hf8,8'h00,8'h5a,8'h02}
  };
  // burst 00 onward with temperature, magnitude and fast read enabled
  localparam logic [7:0] BURST_DATA [6] = '{8'h5a, 8'h3c, 8'hbc, 8'h23, 8'h56, 8'h89};
  localparam logic [7:0] BURST_NEXT [6] = '{8'h01, 8'h02, 8'h04, 8'h06, 8'h08, 8'h00};

  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        addrLoad, readStrobe, readValid, v;
  logic [7:0]  addrIn, readData, readPointer, d, lo;
  logic [7:0]  setTwo = 8'h00;
  logic [7:0]  setFive = 8'h00;
  logic [7:0]  flags = 8'h5a;
  logic [7:0]  temp = 8'h3c;
  logic [11:0] mag = 12'habc;
  logic [11:0] ax = 12'h123;
  logic [11:0] ay = 12'h456;
  logic [11:0] az = 12'h789;
  logic [11:0] sx = 12'hdef;
  logic [5:0]  cnt = 6'h15;
  logic        wmark = 1'b1;
  logic        ovf = 1'b0;
  int          miscompares = 0;
  int          testsRun = 0;
  int          cycles = 0;

  always #2.5 clk = ~clk;

  accel_output_regs accel_output_regs_i (
    .clk(clk), .rstn(rstn), .addrLoad(addrLoad), .addrIn(addrIn), .readStrobe(readStrobe),
    .readData(readData), .readValid(readValid), .readPointer(readPointer),
    .sensorSetupTwo(setTwo), .sensorSetupFive(setFive), .eventFlags(flags),
    .temperature(temp), .magnitude(mag), .accelX(ax), .accelY(ay), .accelZ(az),
    .storeWatermark(wmark), .storeOverflow(ovf), .storeCount(cnt), .storedX(sx));

  accel_host_model host_i (
    .clk(clk), .addrLoad(addrLoad), .addrIn(addrIn), .readStrobe(readStrobe),
    .readData(readData), .readValid(readValid));

  // ***************************************************************
  // checking and closing
  // ***************************************************************
  task automatic checkVal(input string what, input logic [11:0] exp, input logic [11:0] got);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // a hang ends the run well past the fewer than a hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    repeat (2) @(negedge clk);
    checkVal("reset data", 12'h000, {4'h0, readData});
    checkVal("reset pointer", 12'h000, {4'h0, readPointer});
    checkVal("reset valid", 12'h000, {11'h0, readValid});
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    foreach (ROWS[i]) begin
      setTwo = ROWS[i].setTwo;
      setFive = ROWS[i].setFive;
      host_i.loadAddr(ROWS[i].addr, 1'b0);
      host_i.readOne(1'b0, d, v);
      checkVal("row data", {4'h0, ROWS[i].data}, {4'h0, d});
      checkVal("row next", {4'h0, ROWS[i].next}, {4'h0, readPointer});
      checkVal("row valid", 12'h001, {11'h0, v});
    end
    // back-to-back reads, strobe held high across the burst
    setTwo = 8'h06;
    setFive = 8'h08;
    host_i.loadAddr(8'h00, 1'b0);
    for (int k = 0; k < 6; k++) begin
      host_i.readOne(k < 5, d, v);
      checkVal("burst data", {4'h0, BURST_DATA[k]}, {4'h0, d});
      checkVal("burst next", {4'h0, BURST_NEXT[k]}, {4'h0, readPointer});
      checkVal("burst valid", 12'h001, {11'h0, v});
    end
    // two bytes of x rebuilt by the host in the other byte order
    setTwo = 8'h01;
    setFive = 8'h00;
    host_i.loadAddr(8'h04, 1'b0);
    host_i.readOne(1'b1, lo, v);
    host_i.readOne(1'b0, d, v);
    checkVal("joined x", 12'h123, host_i.joinBytes(lo, d, 1'b1));
    // a read strobe alongside a load is dropped
    @(negedge clk);
    host_i.loadAddr(8'h0a, 1'b1);
    checkVal("refused valid", 12'h000, {11'h0, readValid});
    checkVal("refused pointer", 12'h00a, {4'h0, readPointer});
    // store flags and status follow their live inputs, overflow included
    flags = 8'ha5;
    wmark = 1'b0;
    ovf = 1'b1;
    cnt = 6'h2a;
    @(negedge clk);
    host_i.loadAddr(8'h0b, 1'b0);
    host_i.readOne(1'b0, d, v);
    checkVal("store state", 12'h06a, {4'h0, d});
    host_i.loadAddr(8'h00, 1'b0);
    host_i.readOne(1'b0, d, v);
    checkVal("live status", 12'h0a5, {4'h0, d});
    // reset in mid-run returns the port to idle, then reads start at status
    rstn = 1'b0;
    @(negedge clk);
    checkVal("mid reset pointer", 12'h000, {4'h0, readPointer});
    checkVal("mid reset data", 12'h000, {4'h0, readData});
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    host_i.readOne(1'b0, d, v);
    checkVal("after reset data", 12'h0a5, {4'h0, d});
    checkVal("after reset valid", 12'h001, {11'h0, v});
    final_report();
  end
endmodule

`default_nettype wire
